// ==== logic/cabe_pkg.sv ====
// Shared constants, operation codes and carriers of the execution unit.
`default_nettype none
package cabe_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int OFFS_W = 12;
  localparam int CYC_W  = 3;
  localparam int REG_AW = 2;

  // Status flag bit positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;

  // Register offsets.
  localparam logic [REG_AW-1:0] OFS_STATUS = 2'h0;
  localparam logic [REG_AW-1:0] OFS_INFO   = 2'h1;

  // Cycle counts.
  localparam logic [CYC_W-1:0] CYC_ONE   = 3'h1;
  localparam logic [CYC_W-1:0] CYC_TWO   = 3'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 3'h3;
  localparam logic [CYC_W-1:0] CYC_FOUR  = 3'h4;

  // Program counter steps.
  localparam logic [WORD_W-1:0] PC_SKIP_SHORT = 16'h0002;
  localparam logic [WORD_W-1:0] PC_SKIP_LONG  = 16'h0003;
  localparam logic [WORD_W-1:0] PC_REL_BIAS   = 16'h0001;

  typedef enum logic [5:0] {
    add_regs, add_with_carry, add_imm_word,
    sub_regs, sub_const_with_carry, sub_imm_word,
    and_bits, or_bits, xor_bits, clear_bits,
    increment, decrement, test_reg, clear_reg, set_reg,
    mult_unsigned, mult_signed, mult_signed_by_unsigned,
    frac_mult_unsigned, frac_mult_signed, frac_mult_signed_unsigned,
    compare_imm, indirect_jump, indirect_call,
    subroutine_return, interrupt_return,
    compare_skip_equal, skip_reg_bit_clear, skip_reg_bit_set,
    skip_io_bit_clear, skip_io_bit_set,
    branch_status_bit_set, branch_status_bit_clear,
    branch_equal, branch_not_equal, branch_lower, branch_same_or_higher,
    branch_minus, branch_plus, branch_signed_ge, branch_signed_lt,
    branch_half_carry_set, branch_half_carry_clear,
    branch_transfer_bit_set, branch_transfer_bit_clear,
    branch_overflow_set, branch_overflow_clear
  } cabe_op_e;

  typedef struct packed {
    cabe_op_e              op;
    logic [DATA_W-1:0]     dst;
    logic [DATA_W-1:0]     src;
    logic [DATA_W-1:0]     imm;
    logic                  use_imm;
    logic [WORD_W-1:0]     pair;
    logic [WORD_W-1:0]     z_ptr;
    logic [WORD_W-1:0]     pc;
    logic [WORD_W-1:0]     stack_pc;
    logic [OFFS_W-1:0]     offset;
    logic                  next_two_words;
    logic [2:0]            bit_sel;
    logic                  io_bit;
  } cabe_req_s;

  typedef struct packed {
    logic [DATA_W-1:0]     byte_val;
    logic                  byte_we;
    logic [WORD_W-1:0]     word_val;
    logic                  word_we;
    logic                  prod_we;
    logic [WORD_W-1:0]     pc_val;
    logic                  pc_we;
    logic [CYC_W-1:0]      cycles;
  } cabe_res_s;
endpackage
`default_nettype wire

// ==== logic/cabe_core.sv ====
// Execution unit for arithmetic, logic, multiply, jump, skip and branch operations.
//
// Functional notes
// - Add registers, optional carry, five flags, one cycle.
// - Subtract register or constant, optional carry, one cycle.
// - Word add/subtract immediate, five flags, two cycles.
// - Logic ops update only Z, N, V.
// - Inc, dec, test, clear flag; set-register none.
// - Multiplies write pair one:zero, Z and C.
// - Fractional multiplies shift product left by one.
// - Compare computes difference without storing it.
// - Indirect jump loads Z, two cycles.
// - Indirect call loads Z, three cycles.
// - Compare-skip-equal skips one or two words.
// - Register bit skip, one to three cycles.
// - I/O bit skip, one to three cycles.
// - Generic status-bit branch, PC plus k plus one.
// - Carry branches test the carry flag.
// - Signed branches test N xor V; N branches.
// - Half-carry branches test the H flag.
// - Transfer-bit branches test the T flag.
// - Overflow branches test the V flag.
`timescale 1ns/1ps
`default_nettype none
module cabe_core
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          req_valid,
  input  wire cabe_pkg::cabe_req_s           req,
  output logic                               req_ready,
  output logic                               done,
  output cabe_pkg::cabe_res_s                res,
  output logic [cabe_pkg::DATA_W-1:0]        status_flags,
  input  wire logic [cabe_pkg::REG_AW-1:0]   reg_addr,
  input  wire logic [cabe_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic [cabe_pkg::DATA_W-1:0]        reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers.

  // Returns carry out, carry from bit three and the sum.
  function automatic logic [9:0] add8
  (
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       cin
  );
    logic [4:0] lo;
    logic [4:0] hi;
    begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
    end
  endfunction

  // Flags of an eight-bit add or subtract; the operand b is already inverted for a subtract.
  function automatic logic [7:0] arith_flags
  (
    input logic [7:0] old,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [9:0] s,
    input logic       is_sub
  );
    logic [7:0] f;
    begin
      f = old;
      f[cabe_pkg::FLAG_C] = s[9] ^ is_sub;
      f[cabe_pkg::FLAG_H] = s[8] ^ is_sub;
      f[cabe_pkg::FLAG_Z] = (s[7:0] == 8'h00);
      f[cabe_pkg::FLAG_N] = s[7];
      f[cabe_pkg::FLAG_V] = (a[7] == b[7]) && (s[7] != a[7]);
      arith_flags = f;
    end
  endfunction

  // Flags of a logic or count operation: Z and N from the result, V given.
  function automatic logic [7:0] logic_flags
  (
    input logic [7:0] old,
    input logic [7:0] r,
    input logic       v
  );
    logic [7:0] f;
    begin
      f = old;
      f[cabe_pkg::FLAG_Z] = (r == 8'h00);
      f[cabe_pkg::FLAG_N] = r[7];
      f[cabe_pkg::FLAG_V] = v;
      logic_flags = f;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection and shared datapaths.

  typedef enum {st_idle, st_wait} cabe_state_e;

  cabe_state_e                        state;
  logic [1:0]                         remain;
  cabe_pkg::cabe_res_s                pend_res;
  logic [cabe_pkg::DATA_W-1:0]        pend_flags;
  logic [cabe_pkg::CYC_W-1:0]         last_cycles;

  wire        take      = req_valid && req_ready;
  wire [7:0]  operand   = req.use_imm ? req.imm : req.src;
  wire        carry_in  = status_flags[cabe_pkg::FLAG_C];
  wire        sign_flag = status_flags[cabe_pkg::FLAG_N] ^ status_flags[cabe_pkg::FLAG_V];
  wire [9:0]  sum_add   = add8(req.dst, operand, (req.op == cabe_pkg::add_with_carry) & carry_in);
  wire [7:0]  inv_op    = ~operand;
  wire [9:0]  sum_sub   = add8(req.dst, inv_op, ~((req.op == cabe_pkg::sub_const_with_carry) & carry_in));

  // Word arithmetic on the register pair.
  wire [16:0] word_add  = {1'b0, req.pair} + {9'h000, req.imm};
  wire [16:0] word_sub  = {1'b0, req.pair} - {9'h000, req.imm};

  // Multiplier with per-operand signedness.
  wire        mul_a_sgn = (req.op == cabe_pkg::mult_signed) || (req.op == cabe_pkg::frac_mult_signed)
                       || (req.op == cabe_pkg::mult_signed_by_unsigned)
                       || (req.op == cabe_pkg::frac_mult_signed_unsigned);
  wire        mul_b_sgn = (req.op == cabe_pkg::mult_signed) || (req.op == cabe_pkg::frac_mult_signed);
  wire signed [8:0]  mul_a = {mul_a_sgn & req.dst[7], req.dst};
  wire signed [8:0]  mul_b = {mul_b_sgn & req.src[7], req.src};
  wire signed [17:0] mul_p = mul_a * mul_b;
  wire [15:0] product   = mul_p[15:0];
  wire [15:0] product_f = {mul_p[14:0], 1'b0};

  // Targets of skips and relative branches.
  wire [15:0] pc_skip   = req.pc + (req.next_two_words ? cabe_pkg::PC_SKIP_LONG : cabe_pkg::PC_SKIP_SHORT);
  wire [15:0] pc_rel    = req.pc + {{4{req.offset[11]}}, req.offset} + cabe_pkg::PC_REL_BIAS;
  wire [2:0]  skip_cyc  = req.next_two_words ? cabe_pkg::CYC_THREE : cabe_pkg::CYC_TWO;

  ////////////////////////////////////////////////////////////////////////////
  // Result and flag computation for the offered operation.

  cabe_pkg::cabe_res_s          calc;
  logic [cabe_pkg::DATA_W-1:0]  calc_flags;
  logic                         cond;
  logic                         is_skip;
  logic                         is_branch;

  always_comb
  begin
    calc            = '0;
    calc.cycles     = cabe_pkg::CYC_ONE;
    calc_flags      = status_flags;
    cond            = 1'b0;
    is_skip         = 1'b0;
    is_branch       = 1'b0;
    unique case (req.op)
      cabe_pkg::add_regs, cabe_pkg::add_with_carry:
      begin
        calc.byte_val = sum_add[7:0];
        calc.byte_we  = 1'b1;
        calc_flags    = arith_flags(status_flags, req.dst, operand, sum_add, 1'b0);
      end
      cabe_pkg::sub_regs, cabe_pkg::sub_const_with_carry:
      begin
        calc.byte_val = sum_sub[7:0];
        calc.byte_we  = 1'b1;
        calc_flags    = arith_flags(status_flags, req.dst, inv_op, sum_sub, 1'b1);
      end
      cabe_pkg::compare_imm:
      begin
        calc_flags    = arith_flags(status_flags, req.dst, inv_op, sum_sub, 1'b1);
      end
      cabe_pkg::add_imm_word, cabe_pkg::sub_imm_word:
      begin
        calc.cycles   = cabe_pkg::CYC_TWO;
        calc.word_we  = 1'b1;
        if (req.op == cabe_pkg::add_imm_word)
        begin
          calc.word_val = word_add[15:0];
          calc_flags[cabe_pkg::FLAG_C] = word_add[16];
          calc_flags[cabe_pkg::FLAG_V] = ~req.pair[15] & word_add[15];
        end
        else
        begin
          calc.word_val = word_sub[15:0];
          calc_flags[cabe_pkg::FLAG_C] = word_sub[16];
          calc_flags[cabe_pkg::FLAG_V] = req.pair[15] & ~word_sub[15];
        end
        calc_flags[cabe_pkg::FLAG_Z] = (calc.word_val == 16'h0000);
        calc_flags[cabe_pkg::FLAG_N] = calc.word_val[15];
        calc_flags[cabe_pkg::FLAG_S] = calc.word_val[15] ^ calc_flags[cabe_pkg::FLAG_V];
      end
      cabe_pkg::and_bits, cabe_pkg::or_bits, cabe_pkg::xor_bits, cabe_pkg::clear_bits:
      begin
        unique case (req.op)
          cabe_pkg::and_bits:   calc.byte_val = req.dst & operand;
          cabe_pkg::or_bits:    calc.byte_val = req.dst | operand;
          cabe_pkg::xor_bits:   calc.byte_val = req.dst ^ operand;
          default:              calc.byte_val = req.dst & inv_op;
        endcase
        calc.byte_we  = 1'b1;
        calc_flags    = logic_flags(status_flags, calc.byte_val, 1'b0);
      end
      cabe_pkg::increment:
      begin
        calc.byte_val = req.dst + 8'h01;
        calc.byte_we  = 1'b1;
        calc_flags    = logic_flags(status_flags, calc.byte_val, req.dst == 8'h7f);
      end
      cabe_pkg::decrement:
      begin
        calc.byte_val = req.dst - 8'h01;
        calc.byte_we  = 1'b1;
        calc_flags    = logic_flags(status_flags, calc.byte_val, req.dst == 8'h80);
      end
      cabe_pkg::test_reg:
      begin
        calc.byte_val = req.dst & req.dst;
        calc.byte_we  = 1'b1;
        calc_flags    = logic_flags(status_flags, calc.byte_val, 1'b0);
      end
      cabe_pkg::clear_reg:
      begin
        calc.byte_val = req.dst ^ req.dst;
        calc.byte_we  = 1'b1;
        calc_flags    = logic_flags(status_flags, calc.byte_val, 1'b0);
      end
      cabe_pkg::set_reg:
      begin
        calc.byte_val = 8'hff;
        calc.byte_we  = 1'b1;
      end
      cabe_pkg::mult_unsigned, cabe_pkg::mult_signed, cabe_pkg::mult_signed_by_unsigned:
      begin
        calc.cycles   = cabe_pkg::CYC_TWO;
        calc.word_val = product;
        calc.prod_we  = 1'b1;
        calc_flags[cabe_pkg::FLAG_C] = product[15];
        calc_flags[cabe_pkg::FLAG_Z] = (product == 16'h0000);
      end
      cabe_pkg::frac_mult_unsigned, cabe_pkg::frac_mult_signed, cabe_pkg::frac_mult_signed_unsigned:
      begin
        calc.cycles   = cabe_pkg::CYC_TWO;
        calc.word_val = product_f;
        calc.prod_we  = 1'b1;
        calc_flags[cabe_pkg::FLAG_C] = product[15];
        calc_flags[cabe_pkg::FLAG_Z] = (product_f == 16'h0000);
      end
      cabe_pkg::indirect_jump:
      begin
        calc.cycles   = cabe_pkg::CYC_TWO;
        calc.pc_val   = req.z_ptr;
        calc.pc_we    = 1'b1;
      end
      cabe_pkg::indirect_call:
      begin
        calc.cycles   = cabe_pkg::CYC_THREE;
        calc.pc_val   = req.z_ptr;
        calc.pc_we    = 1'b1;
      end
      cabe_pkg::subroutine_return, cabe_pkg::interrupt_return:
      begin
        calc.cycles   = cabe_pkg::CYC_FOUR;
        calc.pc_val   = req.stack_pc;
        calc.pc_we    = 1'b1;
        if (req.op == cabe_pkg::interrupt_return)
        begin
          calc_flags[cabe_pkg::FLAG_I] = 1'b1;
        end
      end
      cabe_pkg::compare_skip_equal:
      begin
        is_skip = 1'b1;
        cond    = (req.dst == req.src);
      end
      cabe_pkg::skip_reg_bit_clear, cabe_pkg::skip_reg_bit_set:
      begin
        is_skip = 1'b1;
        cond    = req.src[req.bit_sel] == (req.op == cabe_pkg::skip_reg_bit_set);
      end
      cabe_pkg::skip_io_bit_clear, cabe_pkg::skip_io_bit_set:
      begin
        is_skip = 1'b1;
        cond    = req.io_bit == (req.op == cabe_pkg::skip_io_bit_set);
      end
      cabe_pkg::branch_status_bit_set, cabe_pkg::branch_status_bit_clear:
      begin
        is_branch = 1'b1;
        cond      = status_flags[req.bit_sel] == (req.op == cabe_pkg::branch_status_bit_set);
      end
      cabe_pkg::branch_equal, cabe_pkg::branch_not_equal:
      begin
        is_branch = 1'b1;
        cond      = status_flags[cabe_pkg::FLAG_Z] == (req.op == cabe_pkg::branch_equal);
      end
      cabe_pkg::branch_lower, cabe_pkg::branch_same_or_higher:
      begin
        is_branch = 1'b1;
        cond      = status_flags[cabe_pkg::FLAG_C] == (req.op == cabe_pkg::branch_lower);
      end
      cabe_pkg::branch_signed_ge, cabe_pkg::branch_signed_lt:
      begin
        is_branch = 1'b1;
        cond      = sign_flag == (req.op == cabe_pkg::branch_signed_lt);
      end
      cabe_pkg::branch_minus, cabe_pkg::branch_plus:
      begin
        is_branch = 1'b1;
        cond      = status_flags[cabe_pkg::FLAG_N] == (req.op == cabe_pkg::branch_minus);
      end
      cabe_pkg::branch_half_carry_set, cabe_pkg::branch_half_carry_clear:
      begin
        is_branch = 1'b1;
        cond      = status_flags[cabe_pkg::FLAG_H] == (req.op == cabe_pkg::branch_half_carry_set);
      end
      cabe_pkg::branch_transfer_bit_set, cabe_pkg::branch_transfer_bit_clear:
      begin
        is_branch = 1'b1;
        cond      = status_flags[cabe_pkg::FLAG_T] == (req.op == cabe_pkg::branch_transfer_bit_set);
      end
      cabe_pkg::branch_overflow_set, cabe_pkg::branch_overflow_clear:
      begin
        is_branch = 1'b1;
        cond      = status_flags[cabe_pkg::FLAG_V] == (req.op == cabe_pkg::branch_overflow_set);
      end
      default:
      begin
        calc.cycles = cabe_pkg::CYC_ONE;
      end
    endcase
    if (is_skip && cond)
    begin
      calc.pc_val = pc_skip;
      calc.pc_we  = 1'b1;
      calc.cycles = skip_cyc;
    end
    if (is_branch && cond)
    begin
      calc.pc_val = pc_rel;
      calc.pc_we  = 1'b1;
      calc.cycles = cabe_pkg::CYC_TWO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing of multi-cycle operations.

  wire        finish_now  = take && (calc.cycles == cabe_pkg::CYC_ONE);
  wire        finish_wait = (state == st_wait) && (remain == 2'h0);
  wire        finishing   = finish_now || finish_wait;
  wire [1:0]  wait_count  = 2'(calc.cycles - cabe_pkg::CYC_TWO);
  wire [7:0]  commit_flag = finish_now ? calc_flags : pend_flags;
  wire cabe_pkg::cabe_res_s commit_res = finish_now ? calc : pend_res;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= st_idle;
      remain     <= 2'h0;
      req_ready  <= 1'b1;
      pend_res   <= '0;
      pend_flags <= cabe_pkg::FLAGS_RST;
    end
    else if (take && !finish_now)
    begin
      state      <= st_wait;
      remain     <= wait_count;
      req_ready  <= 1'b0;
      pend_res   <= calc;
      pend_flags <= calc_flags;
    end
    else if (finish_wait)
    begin
      state      <= st_idle;
      req_ready  <= 1'b1;
    end
    else if (state == st_wait)
    begin
      remain     <= remain - 2'h1;
    end
  end

  // Results are presented for one cycle; a software write loses to a result commit.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      done         <= 1'b0;
      res          <= '0;
      status_flags <= cabe_pkg::FLAGS_RST;
      last_cycles  <= cabe_pkg::CYC_ONE;
    end
    else
    begin
      done <= finishing;
      res  <= finishing ? commit_res : '0;
      if (finishing)
      begin
        status_flags <= commit_flag;
        last_cycles  <= commit_res.cycles;
      end
      else if (reg_write && (reg_addr == cabe_pkg::OFS_STATUS))
      begin
        status_flags <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  wire [7:0] info_word = {4'h0, last_cycles, ~req_ready};
  wire [7:0] read_mux  = (reg_addr == cabe_pkg::OFS_STATUS) ? status_flags
                       : (reg_addr == cabe_pkg::OFS_INFO)   ? info_word : 8'h00;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_read ? read_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ==== tb/cabe_dec_model.sv ====
// Decoder-side model that offers one request at a time and collects the answer.
`timescale 1ns/1ps
`default_nettype none
module cabe_dec_model
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  output logic                     req_valid,
  output cabe_pkg::cabe_req_s      req,
  input  wire logic                req_ready,
  input  wire logic                done,
  input  wire cabe_pkg::cabe_res_s res
);
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end
  // A one-cycle operation shows done right after the taking edge, so the first look is there.
  task automatic issue(input cabe_pkg::cabe_req_s r, output cabe_pkg::cabe_res_s got, output int lat);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= r;
    do
      @(posedge clk);
    while (!req_ready);
    req_valid <= 1'b0;
    lat = 1;
    #1;
    while (!done && lat < 8)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    got = res;
  endtask
endmodule
`default_nettype wire

// ==== tb/cabe_core_asserts.sv ====
// Concurrent checks on the execution unit ports.
`timescale 1ns/1ps
`default_nettype none
module cabe_core_chk
(
  input wire logic                        clk,
  input wire logic                        reset_n,
  input wire logic                        req_valid,
  input wire cabe_pkg::cabe_req_s         req,
  input wire logic                        req_ready,
  input wire logic                        done,
  input wire cabe_pkg::cabe_res_s         res,
  input wire logic [cabe_pkg::DATA_W-1:0] status_flags,
  input wire logic [cabe_pkg::REG_AW-1:0] reg_addr,
  input wire logic [cabe_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_write,
  input wire logic                        reg_read,
  input wire logic [cabe_pkg::DATA_W-1:0] reg_rdata
);
  wire logic take;
  assign take = req_valid && req_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_add_one_cycle: assert property (take && req.op == cabe_pkg::add_regs
    |=> done && res.byte_we && res.cycles == cabe_pkg::CYC_ONE) else $error("add");
  a_sub_diff: assert property (take && req.op == cabe_pkg::sub_regs
    |=> done && res.byte_val == $past(req.dst) - $past(req.src)) else $error("sub");
  a_word_two: assert property (take && req.op == cabe_pkg::add_imm_word
    |=> !done ##1 done && res.word_val == $past(req.pair, 2) + 16'($past(req.imm, 2))) else $error("word add");
  a_logic_keep: assert property (take && req.op == cabe_pkg::and_bits
    |=> done && (status_flags & 8'hf1) == ($past(status_flags) & 8'hf1)) else $error("logic flags");
  a_set_reg: assert property (take && req.op == cabe_pkg::set_reg
    |=> res.byte_val == 8'hff && $stable(status_flags)) else $error("set reg");
  a_mult_prod: assert property (take && req.op == cabe_pkg::mult_unsigned
    |=> !req_ready ##1 done && res.prod_we
    && res.word_val == 16'($past(req.dst, 2)) * 16'($past(req.src, 2))) else $error("product");
  a_cmp_nostore: assert property (take && req.op == cabe_pkg::compare_imm
    |=> done && !res.byte_we) else $error("compare stored");
  a_indirect_jump_z: assert property (take && req.op == cabe_pkg::indirect_jump
    |-> ##2 done && res.pc_we && res.pc_val == $past(req.z_ptr, 2)) else $error("jump");
  a_indirect_call_z: assert property (take && req.op == cabe_pkg::indirect_call
    |-> ##3 done && res.pc_val == $past(req.z_ptr, 3) && res.cycles == cabe_pkg::CYC_THREE) else $error("call");
  c_add: cover property (take && req.op == cabe_pkg::add_regs);
  c_pc: cover property (done && res.pc_we);
  c_prod: cover property (done && res.prod_we);
endmodule
bind cabe_core cabe_core_chk u_chk (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                clk = 1'b0;
  logic                reset_n = 1'b0;
  logic                req_valid;
  cabe_pkg::cabe_req_s req;
  logic                req_ready;
  logic                done;
  cabe_pkg::cabe_res_s res;
  cabe_pkg::cabe_res_s got;
  cabe_pkg::cabe_req_s r;
  logic [7:0]          status_flags;
  logic [1:0]          reg_addr = 2'h0;
  logic [7:0]          reg_wdata = 8'h00;
  logic                reg_write = 1'b0;
  logic                reg_read = 1'b0;
  logic [7:0]          reg_rdata;
  logic [7:0]          rd;
  int                  lat;
  int                  bad_count = 0;
  int                  cmp_count = 0;
  always #5 clk = ~clk;
  cabe_core u_cabe_core (.*);
  cabe_dec_model u_dec (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  function automatic cabe_pkg::cabe_req_s mk(input cabe_pkg::cabe_op_e op, input logic [7:0] d, input logic [7:0] s);
    mk = '0;
    mk.op = op;
    mk.dst = d;
    mk.src = s;
    mk.imm = s;
    mk.pc = 16'h0100;
  endfunction
  task automatic run(input cabe_pkg::cabe_req_s q);
    u_dec.issue(q, got, lat);
  endtask
  task automatic br(input cabe_pkg::cabe_op_e op, input int b, input logic pol);
    logic [7:0] f;
    logic       t;
    for (int i = 0; i < 2; i++)
    begin
      f = (i == 0) ? 8'h00 : 8'h6b;
      reg_wr(2'h0, f);
      r = mk(op, 8'h00, 8'h00);
      r.bit_sel = 3'(b);
      r.offset = 12'hffe;
      t = (((b == 8) ? (f[2] ^ f[3]) : f[b]) == pol);
      run(r);
      chk("branch pc_we", {15'h0, t}, {15'h0, got.pc_we});
      if (t)
        chk("branch pc", 16'h00ff, got.pc_val);
      chk("branch cycles", t ? 16'h2 : 16'h1, 16'(lat));
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    reg_rd(2'h0);
    chk("status reset", 16'h0000, {8'h0, rd});
    reg_wr(2'h0, 8'h5a);
    reg_wr(2'h3, 8'hff);
    reg_rd(2'h3);
    chk("unmapped read", 16'h0000, {8'h0, rd});
    reg_rd(2'h0);
    chk("status readback", 16'h005a, {8'h0, rd});
    $display("t_regs done");
  endtask
  task automatic t_arith;
    reg_wr(2'h0, 8'h01);
    run(mk(cabe_pkg::add_with_carry, 8'hff, 8'h00));
    chk("adc sum", 16'h0000, {8'h0, got.byte_val});
    chk("adc flags", 16'h0023, {8'h0, status_flags});
    chk("adc cycles", 16'h1, 16'(lat));
    reg_wr(2'h0, 8'h00);
    run(mk(cabe_pkg::sub_regs, 8'h10, 8'h01));
    chk("sub diff", 16'h000f, {8'h0, got.byte_val});
    chk("sub flags", 16'h0020, {8'h0, status_flags});
    run(mk(cabe_pkg::compare_imm, 8'h05, 8'h05));
    chk("cmp store", 16'h0000, {15'h0, got.byte_we});
    chk("cmp flags", 16'h0002, {8'h0, status_flags});
    $display("t_arith done");
  endtask
  task automatic t_word;
    r = mk(cabe_pkg::add_imm_word, 8'h00, 8'h01);
    r.pair = 16'hffff;
    run(r);
    chk("word sum", 16'h0000, got.word_val);
    chk("word flags", 16'h0003, {8'h0, status_flags});
    chk("word cycles", 16'h2, 16'(lat));
    run(mk(cabe_pkg::and_bits, 8'hf0, 8'h80));
    chk("and flags", 16'h0005, {8'h0, status_flags});
    run(mk(cabe_pkg::set_reg, 8'h12, 8'h00));
    chk("ser value", 16'h00ff, {8'h0, got.byte_val});
    chk("ser flags", 16'h0005, {8'h0, status_flags});
    $display("t_word done");
  endtask
  task automatic t_mult;
    run(mk(cabe_pkg::mult_unsigned, 8'hff, 8'hff));
    chk("mul prod", 16'hfe01, got.word_val);
    chk("mul flags", 16'h0005, {8'h0, status_flags});
    chk("mul cycles", 16'h2, 16'(lat));
    run(mk(cabe_pkg::frac_mult_unsigned, 8'h80, 8'h80));
    chk("frac_mult_unsigned prod", 16'h8000, got.word_val);
    chk("frac_mult_unsigned flags", 16'h0004, {8'h0, status_flags});
    $display("t_mult done");
  endtask
  task automatic t_jump;
    r = mk(cabe_pkg::indirect_jump, 8'h00, 8'h00);
    r.z_ptr = 16'h1234;
    run(r);
    chk("indirect_jump pc", 16'h1234, got.pc_val);
    chk("indirect_jump cycles", 16'h2, 16'(lat));
    r.op = cabe_pkg::indirect_call;
    run(r);
    chk("indirect_call cycles", 16'h3, 16'(lat));
    r.op = cabe_pkg::interrupt_return;
    r.stack_pc = 16'h0100;
    run(r);
    chk("interrupt_return pc", 16'h0100, got.pc_val);
    chk("interrupt_return cycles", 16'h4, 16'(lat));
    chk("interrupt_return flags", 16'h0084, {8'h0, status_flags});
    reg_rd(2'h1);
    chk("info cycles", 16'h0008, {8'h0, rd});
    $display("t_jump done");
  endtask
  task automatic t_skip;
    r = mk(cabe_pkg::compare_skip_equal, 8'h33, 8'h33);
    r.next_two_words = 1'b1;
    run(r);
    chk("compare_skip_equal pc", 16'h0103, got.pc_val);
    chk("compare_skip_equal cycles", 16'h3, 16'(lat));
    run(mk(cabe_pkg::skip_reg_bit_set, 8'hfe, 8'hfe));
    chk("sbit no skip", 16'h0000, {15'h0, got.pc_we});
    chk("sbit cycles", 16'h1, 16'(lat));
    run(mk(cabe_pkg::skip_io_bit_clear, 8'h00, 8'h00));
    chk("sio pc", 16'h0102, got.pc_val);
    chk("sio cycles", 16'h2, 16'(lat));
    $display("t_skip done");
  endtask
  task automatic t_branch;
    br(cabe_pkg::branch_status_bit_set, 6, 1'b1);
    br(cabe_pkg::branch_status_bit_clear, 6, 1'b0);
    br(cabe_pkg::branch_equal, 1, 1'b1);
    br(cabe_pkg::branch_not_equal, 1, 1'b0);
    br(cabe_pkg::branch_lower, 0, 1'b1);
    br(cabe_pkg::branch_same_or_higher, 0, 1'b0);
    br(cabe_pkg::branch_minus, 2, 1'b1);
    br(cabe_pkg::branch_plus, 2, 1'b0);
    br(cabe_pkg::branch_signed_ge, 8, 1'b0);
    br(cabe_pkg::branch_signed_lt, 8, 1'b1);
    br(cabe_pkg::branch_half_carry_set, 5, 1'b1);
    br(cabe_pkg::branch_half_carry_clear, 5, 1'b0);
    br(cabe_pkg::branch_transfer_bit_set, 6, 1'b1);
    br(cabe_pkg::branch_transfer_bit_clear, 6, 1'b0);
    br(cabe_pkg::branch_overflow_set, 3, 1'b1);
    br(cabe_pkg::branch_overflow_clear, 3, 1'b0);
    $display("t_branch done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_arith();
    t_word();
    t_mult();
    t_jump();
    t_skip();
    t_branch();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
